// *** common/cpu_sfr_pkg.sv ***
// Purpose: Shared constants and types for the CPU status and register space
// Assumes: One 20 MHz clock that is also the oscillator
// Notes: Offsets are direct addresses in the special function area
package cpu_sfr_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int MACHINE_CYCLE_OSC = 12;
	localparam int RESET_HOLD_MC = 2;
	localparam int RESET_HOLD_CYC = RESET_HOLD_MC * MACHINE_CYCLE_OSC;

	// ----------------------------------------------------------------
	// Memory sizes
	// ----------------------------------------------------------------
	localparam int IRAM_BYTES = 256;
	localparam int EXTENDED_INTERNAL_RAM_BYTES = 2048;
	localparam int EXTENDED_INTERNAL_RAM_AW = 11;
	localparam int EXT_AW = 16;
	localparam int SFR_BYTES = 128;
	localparam int NUM_PTRS = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] OFS_STACK_TOP = 8'h81;
	localparam logic [7:0] OFS_EXT_PTR_LOW = 8'h82;
	localparam logic [7:0] OFS_EXT_PTR_HIGH = 8'h83;
	localparam logic [7:0] OFS_POINTER_CHOICE = 8'h92;
	localparam logic [7:0] OFS_STATUS_WORD = 8'hd0;
	localparam logic [7:0] OFS_MAIN_OPERAND = 8'he0;
	localparam logic [7:0] OFS_SECOND_OPERAND = 8'hf0;
	localparam logic [7:0] BIT_IRAM_BASE = 8'h20;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_STACK_TOP = 8'h07;
	localparam logic [7:0] RST_EXT_PTR = 8'h00;
	localparam logic [2:0] RST_POINTER_CHOICE = 3'h0;
	localparam logic [7:0] RST_STATUS_WORD = 8'h00;
	localparam logic [7:0] RST_OPERAND = 8'h00;

	// ----------------------------------------------------------------
	// Status word field positions
	// ----------------------------------------------------------------
	localparam int POS_CARRY = 7;
	localparam int POS_HALF_CARRY = 6;
	localparam int POS_USER_ZERO = 5;
	localparam int POS_BANK_HIGH = 4;
	localparam int POS_BANK_LOW = 3;
	localparam int POS_RANGE = 2;
	localparam int POS_USER_ONE = 1;
	localparam int POS_PARITY = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ARITH_ADD = 3'b001,
		ARITH_ADDC = 3'b010,
		ARITH_SUBB = 3'b100
	} arith_kind_t;

	typedef struct packed
	{
		logic carryFlag;
		logic bcdHalfCarry;
		logic userFlagZero;
		logic bankSelHigh;
		logic bankSelLow;
		logic arithRangeExceeded;
		logic userFlagOne;
		logic parity;
	} status_word_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} byte_req_t;

	typedef struct packed
	{
		logic valid;
		arith_kind_t kind;
		logic [7:0] operand;
	} arith_req_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic value;
	} bit_req_t;

endpackage

// *** rtl/reset_sync.sv ***
// Purpose: Synchronise the external reset and hold the core reset long enough
// Assumes: Pin low for two machine cycles while the clock runs
// Notes: Assert is immediate, release is clocked
`timescale 1ns/100ps
`default_nettype none
module reset_sync
	import cpu_sfr_pkg::*;
#(
	parameter int HOLD_CYC = RESET_HOLD_CYC
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	output logic coreRst_n
);

	// ----------------------------------------------------------------
	// Two-stage release synchroniser
	// ----------------------------------------------------------------
	logic syncA_r;
	logic syncB_r;
	logic [5:0] holdCnt_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
		end
		else if (ce)
		begin
			syncA_r <= 1'b1;
			syncB_r <= syncA_r;
		end
	end

	// ----------------------------------------------------------------
	// Hold stretch
	// ----------------------------------------------------------------
	// Keeps the core in reset a full two machine cycles past release
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			holdCnt_r <= 6'h00;
			coreRst_n <= 1'b0;
		end
		else if (ce && syncB_r && !coreRst_n)
		begin
			if (holdCnt_r == 6'(HOLD_CYC - 1))
				coreRst_n <= 1'b1;
			else
				holdCnt_r <= holdCnt_r + 6'h01;
		end
	end

endmodule
`default_nettype wire

// *** rtl/cpu_status_sfr.sv ***
// Purpose: CPU status word, core registers and internal data spaces
// Assumes: Requests synchronous to clk; one write per memory per cycle
// Notes: Read data returns one clock after the request
//
// Contract
// - Bank bits place registers at 00H-1FH windows
// - Parity follows accumulator after every instruction
// - Reset synchronised, held two machine cycles
// - Bit access in the special register region only where address bits 0-2 zero
// - 128-byte special register region decoded separately
// - 256 internal, 2K extended, 64K external spaces
// - Half carry captures low nibble carry
// - Arithmetic updates carry and signed overflow
`timescale 1ns/100ps
`default_nettype none
module cpu_status_sfr
	import cpu_sfr_pkg::*;
#(
	parameter int IRAM_SIZE = IRAM_BYTES,
	parameter int EXTENDED_INTERNAL_RAM_SIZE = EXTENDED_INTERNAL_RAM_BYTES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire byte_req_t directReq,
	output logic [7:0] directRdata,
	output logic directIsSfr,
	input wire byte_req_t indirectReq,
	output logic [7:0] indirectRdata,
	input wire logic bankRegWr,
	input wire logic bankRegRd,
	input wire logic [2:0] bankRegIdx,
	input wire logic [7:0] bankRegWdata,
	output logic [7:0] bankRegRdata,
	input wire bit_req_t bitReq,
	output logic bitRdata,
	output logic bitAllowed,
	input wire logic xramWr,
	input wire logic xramRd,
	input wire logic [EXTENDED_INTERNAL_RAM_AW-1:0] xramAddr,
	input wire logic [7:0] xramWdata,
	output logic [7:0] xramRdata,
	input wire arith_req_t arithReq,
	output status_word_t statusWord,
	output logic [7:0] mainOperand,
	output logic [7:0] secondOperand,
	output logic [7:0] stackTop,
	output logic [EXT_AW-1:0] extDataAddr,
	output logic resetOut_n
);

	// ----------------------------------------------------------------
	// Reset
	// ----------------------------------------------------------------
	logic coreRst_n;

	reset_sync #(.HOLD_CYC(RESET_HOLD_CYC)) reset_sync_inst
	(
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.coreRst_n(coreRst_n)
	);

	assign resetOut_n = coreRst_n;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] iram [IRAM_SIZE];
	logic [7:0] extended_internal_ram [EXTENDED_INTERNAL_RAM_SIZE];
	logic [7:0] accR;
	logic [7:0] bR;
	logic [7:0] spR;
	logic [7:0] ptrLowR [NUM_PTRS];
	logic [7:0] ptrHighR [NUM_PTRS];
	logic [2:0] ptrSelR;
	status_word_t pswR;
	logic [7:0] directRdata_r;
	logic directIsSfr_r;
	logic [7:0] indirectRdata_r;
	logic [7:0] bankRegRdata_r;
	logic bitRdata_r;
	logic bitAllowed_r;
	logic [7:0] xramRdata_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [7:0] bankAddr;
	logic bitInSfr;
	logic [7:0] bitByteAddr;
	logic [7:0] bitByteOld;
	logic [7:0] bitByteNew;
	logic sfrWr;
	logic [7:0] sfrWrAddr;
	logic [7:0] sfrWrData;
	logic iramWr;
	logic [7:0] iramWrAddr;
	logic [7:0] iramWrData;
	logic parityNow;

	assign bankAddr = {3'b000, pswR.bankSelHigh, pswR.bankSelLow, bankRegIdx};
	assign bitInSfr = bitReq.addr[7];
	// Bit addresses in the special area land only on byte addresses with low bits zero
	assign bitByteAddr = bitInSfr ? {bitReq.addr[7:3], 3'b000}
		: (BIT_IRAM_BASE + {4'h0, bitReq.addr[6:3]});
	assign parityNow = ^accR;

	function automatic logic [7:0] sfrRead(input logic [7:0] addr);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			OFS_STACK_TOP: val = spR;
			OFS_EXT_PTR_LOW: val = ptrLowR[ptrSelR];
			OFS_EXT_PTR_HIGH: val = ptrHighR[ptrSelR];
			OFS_POINTER_CHOICE: val = {5'h00, ptrSelR};
			OFS_STATUS_WORD: val = {pswR[7:1], parityNow};
			OFS_MAIN_OPERAND: val = accR;
			OFS_SECOND_OPERAND: val = bR;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	always_comb
	begin
		bitByteOld = bitInSfr ? sfrRead(bitByteAddr) : iram[bitByteAddr];
		bitByteNew = bitByteOld;
		bitByteNew[bitReq.addr[2:0]] = bitReq.value;
	end

	// Whole-byte write wins over a bit write in the same cycle
	always_comb
	begin
		sfrWr = 1'b0;
		sfrWrAddr = directReq.addr;
		sfrWrData = directReq.wdata;
		if (directReq.wr && directReq.addr[7])
			sfrWr = 1'b1;
		else if (bitReq.wr && bitInSfr)
		begin
			sfrWr = 1'b1;
			sfrWrAddr = bitByteAddr;
			sfrWrData = bitByteNew;
		end
	end

	always_comb
	begin
		iramWr = 1'b1;
		iramWrAddr = directReq.addr;
		iramWrData = directReq.wdata;
		if (directReq.wr && !directReq.addr[7])
			iramWr = 1'b1;
		else if (bankRegWr)
		begin
			iramWrAddr = bankAddr;
			iramWrData = bankRegWdata;
		end
		else if (bitReq.wr && !bitInSfr)
		begin
			iramWrAddr = bitByteAddr;
			iramWrData = bitByteNew;
		end
		else if (indirectReq.wr)
		begin
			iramWrAddr = indirectReq.addr;
			iramWrData = indirectReq.wdata;
		end
		else
			iramWr = 1'b0;
	end

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	// Subtract runs as add of the inverted operand; borrows are inverted carries
	logic isSub;
	logic carryIn;
	logic [7:0] opB;
	logic [4:0] nibbleSum;
	logic [7:0] low7Sum;
	logic [8:0] fullSum;

	assign isSub = (arithReq.kind == ARITH_SUBB);
	assign carryIn = (arithReq.kind == ARITH_ADD) ? 1'b0
		: (isSub ? !pswR.carryFlag : pswR.carryFlag);
	assign opB = isSub ? ~arithReq.operand : arithReq.operand;
	assign nibbleSum = {1'b0, accR[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
	assign low7Sum = {1'b0, accR[6:0]} + {1'b0, opB[6:0]} + {7'h00, carryIn};
	assign fullSum = {1'b0, accR} + {1'b0, opB} + {8'h00, carryIn};

	// ----------------------------------------------------------------
	// Core registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
			accR <= RST_OPERAND;
		else if (ce)
		begin
			if (sfrWr && sfrWrAddr == OFS_MAIN_OPERAND)
				accR <= sfrWrData;
			else if (arithReq.valid)
				accR <= fullSum[7:0];
		end
	end

	// Software write wins over the flag update of the same cycle
	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
			pswR <= RST_STATUS_WORD;
		else if (ce)
		begin
			if (sfrWr && sfrWrAddr == OFS_STATUS_WORD)
				pswR <= {sfrWrData[7:1], 1'b0};
			else if (arithReq.valid)
			begin
				pswR.carryFlag <= isSub ? !fullSum[8] : fullSum[8];
				pswR.bcdHalfCarry <= isSub ? !nibbleSum[4] : nibbleSum[4];
				pswR.arithRangeExceeded <= fullSum[8] ^ low7Sum[7];
			end
		end
	end

	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
		begin
			bR <= RST_OPERAND;
			spR <= RST_STACK_TOP;
			ptrSelR <= RST_POINTER_CHOICE;
		end
		else if (ce && sfrWr)
		begin
			case (sfrWrAddr)
				OFS_SECOND_OPERAND: bR <= sfrWrData;
				OFS_STACK_TOP: spR <= sfrWrData;
				OFS_POINTER_CHOICE: ptrSelR <= sfrWrData[2:0];
				default: ;
			endcase
		end
	end

	// Eight pointer pairs, one visible through the choice register
	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
		begin
			for (int i = 0; i < NUM_PTRS; i++)
			begin
				ptrLowR[i] <= RST_EXT_PTR;
				ptrHighR[i] <= RST_EXT_PTR;
			end
		end
		else if (ce && sfrWr)
		begin
			if (sfrWrAddr == OFS_EXT_PTR_LOW)
				ptrLowR[ptrSelR] <= sfrWrData;
			if (sfrWrAddr == OFS_EXT_PTR_HIGH)
				ptrHighR[ptrSelR] <= sfrWrData;
		end
	end

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	// No reset on the arrays: contents are undefined after power-up
	always_ff @(posedge clk)
	begin
		if (ce && iramWr)
			iram[iramWrAddr] <= iramWrData;
	end

	always_ff @(posedge clk)
	begin
		if (ce && xramWr)
			extended_internal_ram[xramAddr] <= xramWdata;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
		begin
			directRdata_r <= 8'h00;
			directIsSfr_r <= 1'b0;
			indirectRdata_r <= 8'h00;
			bankRegRdata_r <= 8'h00;
			xramRdata_r <= 8'h00;
		end
		else if (ce)
		begin
			if (directReq.rd)
			begin
				directIsSfr_r <= directReq.addr[7];
				directRdata_r <= directReq.addr[7] ? sfrRead(directReq.addr)
					: iram[directReq.addr];
			end
			if (indirectReq.rd)
				indirectRdata_r <= iram[indirectReq.addr];
			if (bankRegRd)
				bankRegRdata_r <= iram[bankAddr];
			if (xramRd)
				xramRdata_r <= extended_internal_ram[xramAddr];
		end
	end

	always_ff @(posedge clk or negedge coreRst_n)
	begin
		if (!coreRst_n)
		begin
			bitRdata_r <= 1'b0;
			bitAllowed_r <= 1'b0;
		end
		else if (ce)
		begin
			bitAllowed_r <= (directReq.addr[2:0] == 3'b000) && directReq.addr[7];
			if (bitReq.rd)
				bitRdata_r <= bitByteOld[bitReq.addr[2:0]];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign directRdata = directRdata_r;
	assign directIsSfr = directIsSfr_r;
	assign indirectRdata = indirectRdata_r;
	assign bankRegRdata = bankRegRdata_r;
	assign bitRdata = bitRdata_r;
	assign bitAllowed = bitAllowed_r;
	assign xramRdata = xramRdata_r;
	assign statusWord = {pswR[7:1], parityNow};
	assign mainOperand = accR;
	assign secondOperand = bR;
	assign stackTop = spR;
	assign extDataAddr = {ptrHighR[ptrSelR], ptrLowR[ptrSelR]};

endmodule
`default_nettype wire

// *** verif/cpu_status_sfr_monitor.sv ***
// Purpose: Port-level checks for the status and register block
// Assumes: One clock, reset_n async active low
// Notes: Arithmetic checks skip cycles where a write to acc or status wins
`timescale 1ns/100ps
`default_nettype none
module cpu_status_sfr_monitor
	import cpu_sfr_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire byte_req_t directReq,
	input wire bit_req_t bitReq,
	input wire arith_req_t arithReq,
	input wire logic directIsSfr,
	input wire logic bitAllowed,
	input wire status_word_t statusWord,
	input wire logic [7:0] mainOperand,
	input wire logic resetOut_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic live, hit, calm, isAdd, cin, half, ovf;
	logic [8:0] sum, dif;
	assign live = ce && resetOut_n;
	assign hit = (directReq.wr && (directReq.addr == OFS_STATUS_WORD
		|| directReq.addr == OFS_MAIN_OPERAND)) || (bitReq.wr && bitReq.addr[7]
		&& (bitReq.addr[7:3] == OFS_STATUS_WORD[7:3] || bitReq.addr[7:3] == OFS_MAIN_OPERAND[7:3]));
	assign calm = live && arithReq.valid && !hit;
	assign isAdd = arithReq.kind != ARITH_SUBB;
	assign cin = (arithReq.kind != ARITH_ADD) && statusWord.carryFlag;
	assign sum = {1'b0, mainOperand} + {1'b0, arithReq.operand} + {8'h00, cin};
	assign dif = {1'b0, mainOperand} - {1'b0, arithReq.operand} - {8'h00, cin};
	assign half = ({1'b0, mainOperand[3:0]} + {1'b0, arithReq.operand[3:0]} + {4'h0, cin}) > 5'h0f;
	assign ovf = (mainOperand[7] == arithReq.operand[7]) && (sum[7] != mainOperand[7]);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_parity;
		statusWord.parity == ^mainOperand;
	endproperty
	a_parity: assert property (p_parity) else $error("parity off");
	property p_status_write;
		live && directReq.wr && directReq.addr == OFS_STATUS_WORD
			|=> statusWord[7:1] == $past(directReq.wdata[7:1]);
	endproperty
	a_status_write: assert property (p_status_write) else $error("status write lost");
	property p_bit_allowed;
		live |=> bitAllowed == $past(directReq.addr[7] && directReq.addr[2:0] == 3'h0);
	endproperty
	a_bit_allowed: assert property (p_bit_allowed) else $error("bit access flag");
	property p_sfr_flag;
		live && directReq.rd |=> directIsSfr == $past(directReq.addr[7]);
	endproperty
	a_sfr_flag: assert property (p_sfr_flag) else $error("special area flag");
	property p_add;
		calm && isAdd |=> {statusWord.carryFlag, mainOperand} == $past(sum);
	endproperty
	a_add: assert property (p_add) else $error("add result");
	property p_sub;
		calm && !isAdd |=> {statusWord.carryFlag, mainOperand} == $past(dif);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result");
	property p_half;
		calm && isAdd |=> statusWord.bcdHalfCarry == $past(half);
	endproperty
	a_half: assert property (p_half) else $error("half carry");
	property p_ovf;
		calm && isAdd |=> statusWord.arithRangeExceeded == $past(ovf);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow");
	property p_reset_low;
		$rose(reset_n) |-> !resetOut_n [*8];
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("reset released early");
	property p_reset_bound;
		$rose(reset_n) |-> ##[20:40] resetOut_n;
	endproperty
	a_reset_bound: assert property (p_reset_bound) else $error("reset stuck");
	c_sub: cover property (calm && !isAdd);
	c_bit: cover property (live && bitAllowed);
	c_release: cover property ($rose(resetOut_n));
endmodule
bind cpu_status_sfr cpu_status_sfr_monitor cpu_status_sfr_monitor_inst
(
	.clk, .reset_n, .ce, .directReq, .bitReq, .arithReq, .directIsSfr, .bitAllowed,
	.statusWord, .mainOperand, .resetOut_n
);
`default_nettype wire

// *** verif/test_cpu_status_sfr.sv ***
// Purpose: Self-checking bench for the status and register block
// Assumes: 20 MHz clock, reset_n async active low
// Notes: Full reset stretch kept, the run stays short
`timescale 1ns/100ps
`default_nettype none
module test_cpu_status_sfr
	import cpu_sfr_pkg::*;
;
	logic clk, reset_n, ce, directIsSfr, bitRdata, bitAllowed, resetOut_n;
	logic bankRegWr, bankRegRd, xramWr, xramRd;
	byte_req_t directReq, indirectReq;
	bit_req_t bitReq;
	arith_req_t arithReq;
	status_word_t statusWord;
	logic [2:0] bankRegIdx;
	logic [7:0] bankRegWdata, xramWdata, directRdata, indirectRdata, bankRegRdata, q;
	logic [7:0] xramRdata, mainOperand, secondOperand, stackTop;
	logic [EXTENDED_INTERNAL_RAM_AW-1:0] xramAddr;
	logic [EXT_AW-1:0] extDataAddr;
	logic [10:0] e;
	int errors, compares, n;
	logic [7:0] ra [7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h85};
	logic [7:0] rv [7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] av [5] = '{8'h7f, 8'hff, 8'h00, 8'h80, 8'h0f};
	logic [7:0] bv [5] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
	logic [2:0] kv [5] = '{3'b001, 3'b010, 3'b100, 3'b100, 3'b010};
	logic cv [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	cpu_status_sfr cpu_status_sfr_inst
	(
		.clk, .reset_n, .ce, .directReq, .directRdata, .directIsSfr, .indirectReq,
		.indirectRdata, .bankRegWr, .bankRegRd, .bankRegIdx, .bankRegWdata, .bankRegRdata,
		.bitReq, .bitRdata, .bitAllowed, .xramWr, .xramRd, .xramAddr, .xramWdata, .xramRdata,
		.arithReq, .statusWord, .mainOperand, .secondOperand, .stackTop, .extDataAddr, .resetOut_n
	);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One request on port k, answer sampled once the taking edge has landed
	task automatic op(input int k, input logic wr, input logic [10:0] a, input logic [7:0] d);
		@(posedge clk);
		case (k)
			0: directReq <= '{wr, !wr, a[7:0], d};
			1: indirectReq <= '{wr, !wr, a[7:0], d};
			2: {bankRegWr, bankRegRd, bankRegIdx, bankRegWdata} <= {wr, !wr, a[2:0], d};
			3: bitReq <= '{wr, !wr, a[7:0], d[0]};
			4: {xramWr, xramRd, xramAddr, xramWdata} <= {wr, !wr, a, d};
			default: arithReq <= '{1'b1, arith_kind_t'(a[2:0]), d};
		endcase
		@(posedge clk);
		directReq <= '0;
		indirectReq <= '0;
		bitReq <= '0;
		arithReq <= '0;
		{bankRegWr, bankRegRd, xramWr, xramRd} <= 4'h0;
		#1;
		case (k)
			0: q = directRdata;
			1: q = indirectRdata;
			2: q = bankRegRdata;
			3: q = {7'h00, bitRdata};
			default: q = xramRdata;
		endcase
	endtask
	task automatic do_reset(input int len);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (len) @(posedge clk);
		#1 chk("rstout", resetOut_n, 1'b0);
		@(posedge clk);
		reset_n <= 1'b1;
		n = 0;
		while (resetOut_n !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		// A stuck release must not slip through on the loop limit
		chk("released", resetOut_n, 1'b1);
	endtask
	function automatic logic [10:0] model(input logic [2:0] k, input logic [7:0] a,
		input logic [7:0] b, input logic c);
		logic [8:0] r;
		logic h;
		logic v;
		if (k == 3'b001)
			c = 1'b0;
		if (k == 3'b100)
		begin
			r = {1'b0, a} - {1'b0, b} - {8'h00, c};
			h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, c});
			v = (a[7] != b[7]) && (r[7] != a[7]);
		end
		else
		begin
			r = {1'b0, a} + {1'b0, b} + {8'h00, c};
			h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c}) > 5'h0f;
			v = (a[7] == b[7]) && (r[7] != a[7]);
		end
		return {r[8], h, v, r[7:0]};
	endfunction
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end
	initial
	begin
		{reset_n, ce, bankRegWr, bankRegRd, xramWr, xramRd} = 6'h00;
		{directReq, indirectReq, bitReq, arithReq} = '0;
		{bankRegIdx, bankRegWdata, xramAddr, xramWdata} = '0;
		ce <= 1'b1;
		do_reset(16);
		for (int i = 0; i < 7; i++)
		begin
			op(0, 1'b0, {3'h0, ra[i]}, 8'h00);
			chk("reset value", q, rv[i]);
		end
		op(0, 1'b0, 11'h092, 8'h00);
		chk("choice", q[2:0], 3'h0);
		for (int i = 0; i < 6; i++)
		begin
			if (i == 3)
				continue;
			op(0, 1'b1, {3'h0, ra[i]}, 8'h5a ^ i[7:0]);
			op(0, 1'b0, {3'h0, ra[i]}, 8'h00);
			chk("readback", q, 8'h5a ^ i[7:0]);
		end
		chk("stack out", stackTop, 8'h5a);
		chk("b out", secondOperand, 8'h5f);
		// Another pointer pair must not disturb pair zero
		op(0, 1'b1, 11'h092, 8'h03);
		op(0, 1'b1, 11'h082, 8'h11);
		chk("ptr sel", extDataAddr, 16'h0011);
		op(0, 1'b0, 11'h092, 8'h00);
		chk("choice set", q, 8'h03);
		op(0, 1'b1, 11'h092, 8'h00);
		chk("ptr", extDataAddr, 16'h585b);
		// A write offered while frozen must not land
		@(posedge clk) ce <= 1'b0;
		op(0, 1'b1, 11'h0f0, 8'ha5);
		chk("frozen", secondOperand, 8'h5f);
		@(posedge clk) ce <= 1'b1;
		$display("registers done");
		for (int b = 0; b < 4; b++)
		begin
			op(0, 1'b1, 11'h0d0, {3'h0, b[1:0], 3'h0});
			op(2, 1'b1, 11'h005, 8'h30 + b[7:0]);
			op(1, 1'b0, {6'h00, b[1:0], 3'h5}, 8'h00);
			chk("bank", q, 8'h30 + b[7:0]);
			op(2, 1'b0, 11'h005, 8'h00);
			chk("bank read", q, 8'h30 + b[7:0]);
		end
		op(0, 1'b1, 11'h0e0, 8'h03);
		op(0, 1'b1, 11'h0d0, 8'h01);
		op(0, 1'b0, 11'h0d0, 8'h00);
		chk("parity write", q, 8'h00);
		op(0, 1'b1, 11'h0e0, 8'h07);
		chk("parity", statusWord.parity, 1'b1);
		$display("status done");
		for (int a = 8'h78; a < 8'h98; a++)
		begin
			op(0, 1'b0, a[10:0], 8'h00);
			chk("bitok", bitAllowed, a[7] && a[2:0] == 3'h0);
			chk("is sfr", directIsSfr, a[7]);
		end
		op(1, 1'b1, 11'h021, 8'h00);
		op(3, 1'b1, 11'h00b, 8'h01);
		op(1, 1'b0, 11'h021, 8'h00);
		chk("ram bit", q, 8'h08);
		op(0, 1'b1, 11'h0e0, 8'h00);
		op(3, 1'b1, 11'h0e2, 8'h01);
		chk("acc bit", mainOperand, 8'h04);
		op(3, 1'b0, 11'h0e2, 8'h00);
		chk("bit read", q, 8'h01);
		$display("bits done");
		for (int i = 0; i < 5; i++)
		begin
			op(0, 1'b1, 11'h0e0, av[i]);
			op(0, 1'b1, 11'h0d0, {cv[i], 7'h00});
			op(5, 1'b1, {8'h00, kv[i]}, bv[i]);
			e = model(kv[i], av[i], bv[i], cv[i]);
			chk("acc", mainOperand, e[7:0]);
			chk("cy ov", {statusWord.carryFlag, statusWord.arithRangeExceeded}, {e[10], e[8]});
			chk("half", statusWord.bcdHalfCarry, e[9]);
			chk("parity", statusWord.parity, ^e[7:0]);
		end
		$display("arithmetic done");
		op(4, 1'b1, 11'h7ff, 8'h3c);
		op(4, 1'b1, 11'h000, 8'hc3);
		op(4, 1'b0, 11'h7ff, 8'h00);
		chk("extended_internal_ram top", q, 8'h3c);
		op(4, 1'b0, 11'h000, 8'h00);
		chk("extended_internal_ram base", q, 8'hc3);
		op(1, 1'b1, 11'h0ff, 8'ha7);
		op(1, 1'b0, 11'h0ff, 8'h00);
		chk("iram top", q, 8'ha7);
		op(0, 1'b1, 11'h030, 8'h66);
		op(0, 1'b0, 11'h030, 8'h00);
		chk("direct ram", q, 8'h66);
		op(1, 1'b0, 11'h030, 8'h00);
		chk("same byte", q, 8'h66);
		$display("memories done");
		// Pin held low the full two machine cycles
		do_reset(RESET_HOLD_CYC);
		chk("hold", n >= RESET_HOLD_CYC, 1'b1);
		chk("acc reset", mainOperand, 8'h00);
		chk("stack reset", stackTop, 8'h07);
		$display("reset done");
		complete_run();
	end
endmodule
`default_nettype wire
